// >>> core/dir_reg.v
// One write-only direction register with per-bit mask.
// Assumes the caller supplies a one-cycle write strobe on pclk.
`include "port_dir_map.vh"
`default_nettype none
module dir_reg #(
    parameter [7:0] MASK = 8'hFF
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Reset value chosen by the caller
    input wire [7:0] reset_value,
    input wire load_reset,
    // Write side
    input wire wr_en,
    input wire [7:0] wr_data,
    // Direction out
    output wire [7:0] dir
);
    reg [7:0] dir_r;

    // Async reset loads constant zero; strap value loads on the edge where load_reset is high
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dir_r <= `RST_ZERO;
        else if (load_reset)
            dir_r <= reset_value & MASK;
        else if (wr_en)
            dir_r <= wr_data & MASK;
    end

    // Unimplemented bits drive low: pin stays input
    assign dir = dir_r & MASK;
endmodule // dir_reg
`default_nettype wire

// >>> core/port_direction_regs.v
// APB slave holding the direction registers of all ports.
// Assumes mode and rom_present are static straps, synchronised here.
`include "port_dir_map.vh"
`default_nettype none

// Summary of operation
// - Each bit sets its pin's direction
// - Direction bits are write-only, reads return zero
// - Ports 1, 2, A, D, E reset cleared
// - Port 3 implements bits 5..0 only
// - Port 5 implements bits 3..0 only
// - Ports B and C exist with ROM only
// - F7 and G4 reset depend on mode
module port_direction_regs (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // Straps
    input wire [2:0] mode,
    input wire rom_present,
    // Output driver enables, one per pin
    output wire [7:0] port1_oe,
    output wire [7:0] port2_oe,
    output wire [7:0] port3_oe,
    output wire [7:0] port5_oe,
    output wire [7:0] porta_oe,
    output wire [7:0] portb_oe,
    output wire [7:0] portc_oe,
    output wire [7:0] portd_oe,
    output wire [7:0] porte_oe,
    output wire [7:0] portf_oe,
    output wire [7:0] portg_oe
);
    localparam NREG = 11;
    // Bank slots that differ from a plain eight-bit register
    localparam SLOT_PORT3 = 2;
    localparam SLOT_PORT5 = 3;
    localparam SLOT_PORTB = 5;
    localparam SLOT_PORTC = 6;
    localparam SLOT_PORTF = 9;
    localparam SLOT_PORTG = 10;
    localparam [1:0] ST_RESET = 2'h0;
    localparam [1:0] ST_SYNC = 2'h1;
    localparam [1:0] ST_LOAD = 2'h2;
    localparam [1:0] ST_RUN = 2'h3;

    reg [2:0] mode_s1_r;
    reg [2:0] mode_s2_r;
    reg rom_s1_r;
    reg rom_s2_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [7:0] portf_rst;
    reg [7:0] portg_rst;
    reg [31:0] prdata_nxt;
    wire load_reset;
    wire access;
    wire setup;
    wire not_ready;
    wire unmapped;
    wire no_rom;
    wire status_sel;
    wire [15:0] idx;
    wire [NREG-1:0] sel;
    wire [NREG-1:0] wr;
    wire [7:0] dir [0:NREG-1];

    // Register select from a word address
    function [NREG-1:0] decode;
        input [15:0] i;
        begin
            decode = {NREG{1'b0}};
            if (i == `IDX_PORT1)
            begin
                decode[0] = 1'b1;
            end
            else if (i == `IDX_PORT2)
            begin
                decode[1] = 1'b1;
            end
            else if (i == `IDX_PORT3)
            begin
                decode[2] = 1'b1;
            end
            else if (i == `IDX_PORT5)
            begin
                decode[3] = 1'b1;
            end
            else if (i == `IDX_PORTA)
            begin
                decode[4] = 1'b1;
            end
            else if (i == `IDX_PORTB)
            begin
                decode[5] = 1'b1;
            end
            else if (i == `IDX_PORTC)
            begin
                decode[6] = 1'b1;
            end
            else if (i == `IDX_PORTD)
            begin
                decode[7] = 1'b1;
            end
            else if (i == `IDX_PORTE)
            begin
                decode[8] = 1'b1;
            end
            else if (i == `IDX_PORTF)
            begin
                decode[9] = 1'b1;
            end
            else if (i == `IDX_PORTG)
            begin
                decode[10] = 1'b1;
            end
        end
    endfunction

    // Implemented bits per bank slot
    function [7:0] bit_mask;
        input integer slot;
        begin
            if (slot == SLOT_PORT3)
                bit_mask = `MASK_PORT3;
            else if (slot == SLOT_PORT5)
                bit_mask = `MASK_PORT5;
            else if (slot == SLOT_PORTG)
                bit_mask = `MASK_PORTG;
            else
                bit_mask = `MASK_FULL;
        end
    endfunction

    // Reset pattern per bank slot; only F and G follow the mode
    function [7:0] reset_pattern;
        input integer slot;
        input [7:0] f_val;
        input [7:0] g_val;
        begin
            if (slot == SLOT_PORTF)
                reset_pattern = f_val;
            else if (slot == SLOT_PORTG)
                reset_pattern = g_val;
            else
                reset_pattern = `RST_ZERO;
        end
    endfunction

    // Strap synchronisers; only the second stage feeds logic
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_s1_r <= `MODE_7;
            mode_s2_r <= `MODE_7;
        end
        else
        begin
            mode_s1_r <= mode;
            mode_s2_r <= mode_s1_r;
        end
    end

    // ROM strap resets low, so B and C stay refused until known
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rom_s1_r <= 1'b0;
            rom_s2_r <= 1'b0;
        end
        else
        begin
            rom_s1_r <= rom_present;
            rom_s2_r <= rom_s1_r;
        end
    end

    // Mode-dependent reset values, caught after release
    always @*
    begin
        portf_rst = `RST_ZERO;
        portg_rst = `RST_ZERO;
        if (mode_s2_r == `MODE_4 || mode_s2_r == `MODE_5 ||
            mode_s2_r == `MODE_6)
        begin
            portf_rst = `RST_F_HIGH;
        end
        if (mode_s2_r == `MODE_4 || mode_s2_r == `MODE_5)
        begin
            portg_rst = `RST_G_HIGH;
        end
    end

    // Two edges fill the synchronisers before the one-time load
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_RESET:
            begin
                state_nxt = ST_SYNC;
            end
            ST_SYNC:
            begin
                state_nxt = ST_LOAD;
            end
            ST_LOAD:
            begin
                state_nxt = ST_RUN;
            end
            default:
            begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_r <= ST_RESET;
        else
            state_r <= state_nxt;
    end

    assign load_reset = (state_r == ST_LOAD);

    // Zero-wait APB; accesses before straps settle are refused
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign pready = 1'b1;
    assign idx = paddr[17:2];
    assign sel = decode(idx);
    assign status_sel = (idx == `IDX_STATUS);

    // Reasons to refuse a transfer
    assign not_ready = (state_r != ST_RUN);
    assign unmapped = (sel == {NREG{1'b0}}) & ~status_sel;
    assign no_rom = (sel[SLOT_PORTB] | sel[SLOT_PORTC]) &
        ~rom_s2_r;
    assign pslverr = access & (not_ready | unmapped | no_rom);

    // Refused writes leave every register alone
    assign wr = (access & pwrite & ~pslverr) ? sel : {NREG{1'b0}};

    // Read returns only strap status; direction bits read zero
    always @*
    begin
        prdata_nxt = 32'h0000_0000;
        if (setup & ~pwrite & status_sel)
        begin
            prdata_nxt = {28'h000_0000, rom_s2_r, mode_s2_r};
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (setup)
            prdata <= prdata_nxt;
    end

    // Register bank
    genvar g;
    generate
        for (g = 0; g < NREG; g = g + 1)
        begin : bank
            localparam [7:0] MASK = bit_mask(g);
            wire [7:0] rst_val;
            assign rst_val = reset_pattern(g, portf_rst,
                portg_rst);
            dir_reg #(.MASK(MASK)) u_reg (
                .pclk(pclk),
                .presetn(presetn),
                .reset_value(rst_val),
                .load_reset(load_reset),
                .wr_en(wr[g]),
                .wr_data(pwdata[7:0]),
                .dir(dir[g])
            );
        end
    endgenerate

    // One enables the pin driver
    assign port1_oe = dir[0];
    assign port2_oe = dir[1];
    assign port3_oe = dir[SLOT_PORT3];
    assign port5_oe = dir[SLOT_PORT5];
    assign porta_oe = dir[4];

    // Without ROM the B and C pins never drive, whatever was stored
    assign portb_oe = rom_s2_r ? dir[SLOT_PORTB] : `RST_ZERO;
    assign portc_oe = rom_s2_r ? dir[SLOT_PORTC] : `RST_ZERO;
    assign portd_oe = dir[7];
    assign porte_oe = dir[8];
    assign portf_oe = dir[9];
    assign portg_oe = dir[10];
endmodule // port_direction_regs
`default_nettype wire

// >>> inc/port_dir_map.vh
// Register map and reset constants for the port direction bank.
// Assumes APB byte addresses; offsets not multiples of four are indexes.
`ifndef PORT_DIR_MAP_VH
`define PORT_DIR_MAP_VH

// Register indexes; byte address is four times the index
`define IDX_PORT1 16'hFEB0
`define IDX_PORT2 16'hFEB1
`define IDX_PORT3 16'hFEB2
`define IDX_PORT5 16'hFEB4
`define IDX_PORTA 16'hFEB9
`define IDX_PORTB 16'hFEBA
`define IDX_PORTC 16'hFEBB
`define IDX_PORTD 16'hFEBC
`define IDX_PORTE 16'hFEBD
`define IDX_PORTF 16'hFEBE
`define IDX_PORTG 16'hFEBF
// Status register index showing mode and variant
`define IDX_STATUS 16'hFEC0

// Implemented bit masks
`define MASK_FULL 8'hFF
`define MASK_PORT3 8'h3F
`define MASK_PORT5 8'h0F
`define MASK_PORTG 8'h1F

// Reset values
`define RST_ZERO 8'h00
`define RST_F_HIGH 8'h80
`define RST_G_HIGH 8'h10

// Operating mode codes
`define MODE_W 3
`define MODE_4 3'h4
`define MODE_5 3'h5
`define MODE_6 3'h6
`define MODE_7 3'h7

`endif

// >>> sim/port_dir_asserts.sv
// Checker for the port direction bank, bound to its top module.
// Assumes the straps change only while reset is held.
`include "port_dir_map.vh"
`default_nettype none
module port_dir_asserts (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Straps and enables
    input wire logic [2:0] mode,
    input wire logic rom_present,
    input wire logic [7:0] port1_oe,
    input wire logic [7:0] port3_oe,
    input wire logic [7:0] port5_oe,
    input wire logic [7:0] portb_oe,
    input wire logic [7:0] portc_oe,
    input wire logic [7:0] portf_oe,
    input wire logic [7:0] portg_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc = psel & penable;
    wire logic [15:0] ix = paddr[17:2];
    wire logic [7:0] wd = pwdata[7:0];
    a_p1_write: assert property (acc && pwrite && ix == `IDX_PORT1 &&
        !pslverr |=> port1_oe == $past(wd)) else $error("port1 write lost");
    a_p1_hold: assert property (!(acc && pwrite && ix == `IDX_PORT1)
        |=> $stable(port1_oe)) else $error("port1 changed unasked");
    a_rd_zero: assert property (acc && !pwrite && ix >= `IDX_PORT1 &&
        ix <= `IDX_PORTG |-> prdata == 32'h0) else $error("readback seen");
    a_p3_top: assert property (port3_oe[7:6] == 2'h0)
        else $error("port3 top bits set");
    a_p5_top: assert property (port5_oe[7:4] == 4'h0)
        else $error("port5 top bits set");
    a_bc_norom: assert property (!rom_present |->
        portb_oe == 8'h00 && portc_oe == 8'h00) else $error("b/c without rom");
    a_pf_reset: assert property ($rose(presetn) |-> ##3
        portf_oe == {mode != `MODE_7, 7'h00}) else $error("port f reset");
    a_pg_reset: assert property ($rose(presetn) |-> ##3
        portg_oe == {3'h0, mode == `MODE_4 || mode == `MODE_5, 4'h0})
        else $error("port g reset");
endmodule // port_dir_asserts
bind port_direction_regs port_dir_asserts u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .mode(mode), .rom_present(rom_present),
    .port1_oe(port1_oe), .port3_oe(port3_oe), .port5_oe(port5_oe),
    .portb_oe(portb_oe), .portc_oe(portc_oe), .portf_oe(portf_oe),
    .portg_oe(portg_oe)
);
`default_nettype wire

// >>> sim/port_direction_regs_tb.sv
// Self-checking bench for the port direction bank over APB.
// Assumes zero-wait answers; straps change only in reset.
`include "port_dir_map.vh"
`default_nettype none
module port_direction_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk, presetn, psel, penable, pwrite, rom_present;
    logic pready, pslverr, er;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [2:0] mode;
    wire logic [7:0] oes [11];
    int error_cnt, samples_checked;
    // Index, write data, expected enables; order follows oes
    localparam logic [31:0] ROW [11] = '{{`IDX_PORT1, 16'hA5A5},
        {`IDX_PORT2, 16'h5A5A}, {`IDX_PORT3, 16'hFF3F},
        {`IDX_PORT5, 16'hFF0F}, {`IDX_PORTA, 16'h8181},
        {`IDX_PORTB, 16'hC3C3}, {`IDX_PORTC, 16'h3C3C},
        {`IDX_PORTD, 16'h7E7E}, {`IDX_PORTE, 16'hE7E7},
        {`IDX_PORTF, 16'h0101}, {`IDX_PORTG, 16'hFF1F}};
    port_direction_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .mode(mode),
        .rom_present(rom_present), .port1_oe(oes[0]), .port2_oe(oes[1]),
        .port3_oe(oes[2]), .port5_oe(oes[3]), .porta_oe(oes[4]),
        .portb_oe(oes[5]), .portc_oe(oes[6]), .portd_oe(oes[7]),
        .porte_oe(oes[8]), .portf_oe(oes[9]), .portg_oe(oes[10]));
    task stop_test();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    // Idle cycle between transfers keeps one assignment per time step
    task apb(input logic [15:0] ix, input logic w, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {14'h0, ix, 2'h0};
        pwdata <= {24'hFFFFFF, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            error_cnt++;
            stop_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rst(input logic [2:0] m, input logic r, input int settle);
        @(posedge pclk);
        presetn <= 1'b0;
        mode <= m;
        rom_present <= r;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (settle) @(posedge pclk);
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        mode = 3'h4;
        rom_present = 1'b1;
        rst(3'h4, 1'b1, 5);
        for (int k = 0; k < 11; k++)
        begin
            apb(ROW[k][31:16], 1'b1, ROW[k][15:8]);
            chk(er, 1'b0);
            apb(ROW[k][31:16], 1'b0, 8'h00);
            chk(oes[k], ROW[k][7:0]);
            chk(rd, 32'h0);
        end
        for (int k = 0; k < 11; k++)
            chk(oes[k], ROW[k][7:0]);
        $display("test row writes done");
        apb(`IDX_STATUS, 1'b0, 8'h00);
        chk(rd, {28'h0, 1'b1, 3'h4});
        $display("test status read done");
        // Mid-run resets in modes 4 to 7 must restore reset values, the first over the written rows, F and G per mode
        for (int m = 4; m < 8; m++)
        begin
            rst(3'(m), m != 7, 5);
            for (int k = 0; k < 11; k++)
                chk(oes[k], (k == 9 && m < 7) ? 8'h80 :
                    (k == 10 && m < 6) ? 8'h10 : 8'h00);
        end
        $display("test reset values done");
        apb(`IDX_PORTB, 1'b1, 8'hFF);
        chk(er, 1'b1);
        chk(oes[5], 8'h00);
        apb(16'h0100, 1'b1, 8'hFF);
        chk(er, 1'b1);
        $display("test refusals done");
        // Access phase lands before the straps settle
        rst(3'h4, 1'b1, 0);
        apb(`IDX_PORT1, 1'b1, 8'hFF);
        chk(er, 1'b1);
        chk(oes[0], 8'h00);
        $display("test early access done");
        stop_test();
    end
endmodule // port_direction_regs_tb
`default_nettype wire
